// file: hdl/fchs_host.sv
// Our own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ns
module fchs_host #(
  parameter int LOAD_END_CYC = fchs_pkg::LOAD_END_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  output logic             flashCeN,
  output logic             flashOeN,
  output logic             flashWeN,
  output logic             flashByteN,
  output logic             identifierHighVoltage,
  output logic [19:0]      flashAddr,
  input  wire logic [15:0] dqIn,
  output logic [15:0]      dqOut,
  output logic [15:0]      dqOeN
);
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001, S_SETUP = 6'b000010, S_STROBE = 6'b000100,
    S_RECOV = 6'b001000, S_RDWAIT = 6'b010000, S_LOADEND = 6'b100000
  } fchs_state_t;

  logic [15:0] pbuf [0:fchs_pkg::PAGE_BYTES-1];
  logic        wrPend_r, wrPend_nxt;
  logic [7:0]  wrOff_r, wrOff_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic [1:0]  ctrl_r, ctrl_nxt;
  logic [19:0] addrReg_r, addrReg_nxt;
  logic [15:0] wdata_r, wdata_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [7:0]  plen_r, plen_nxt;
  logic [6:0]  pidx_r, pidx_nxt;
  logic        bufWr;
  logic        addrPhase;
  fchs_state_t st_r, st_nxt;
  fchs_pkg::fchs_op_t op_r, op_nxt;
  logic [7:0]  step_r, step_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic        byteMode_r, byteMode_nxt;
  logic        ceN_r, ceN_nxt, oeN_r, oeN_nxt, weN_r, weN_nxt;
  logic [19:0] fa_r, fa_nxt;
  logic [15:0] dqo_r, dqo_nxt, dqoe_r, dqoe_nxt;
  logic [7:0]  lastStep;
  logic [19:0] stepAddr;
  logic [15:0] stepData;
  logic [6:0]  ldIdx;
  logic        isRead;

  // zero wait state slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign addrPhase = hsel & htrans[1] & hready;

  always_comb begin
    wrPend_nxt = addrPhase & hwrite;
    wrOff_nxt = addrPhase ? haddr[7:0] : wrOff_r;
    hrdata_nxt = hrdata_r;
    ctrl_nxt = ctrl_r;
    addrReg_nxt = addrReg_r;
    wdata_nxt = wdata_r;
    plen_nxt = plen_r;
    pidx_nxt = pidx_r;
    bufWr = 1'b0;
    if (addrPhase && !hwrite) begin
      unique case (haddr[7:0])
        fchs_pkg::OFF_CTRL:   hrdata_nxt = {30'h0000_0000, ctrl_r};
        fchs_pkg::OFF_ADDR:   hrdata_nxt = {12'h000, addrReg_r};
        fchs_pkg::OFF_WDATA:  hrdata_nxt = {16'h0000, wdata_r};
        fchs_pkg::OFF_RDATA:  hrdata_nxt = {16'h0000, rdata_r};
        fchs_pkg::OFF_STATUS: hrdata_nxt = {29'h0000_0000, rdata_r[fchs_pkg::DQ_SUSP_BIT],
                                            rdata_r[fchs_pkg::DQ_READY_BIT], st_r != S_IDLE};
        fchs_pkg::OFF_PLEN:   hrdata_nxt = {24'h00_0000, plen_r};
        default:              hrdata_nxt = 32'h0000_0000;
      endcase
    end
    if (wrPend_r) begin
      unique case (wrOff_r)
        fchs_pkg::OFF_CTRL:  ctrl_nxt = hwdata[1:0];
        fchs_pkg::OFF_ADDR:  addrReg_nxt = hwdata[19:0];
        fchs_pkg::OFF_WDATA: wdata_nxt = hwdata[15:0];
        fchs_pkg::OFF_PLEN: begin
          plen_nxt = hwdata[7:0];
          pidx_nxt = 7'h00;
        end
        fchs_pkg::OFF_PBUF: begin
          bufWr = 1'b1;
          pidx_nxt = pidx_r + 7'h01;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wrPend_r <= 1'b0;
      wrOff_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
      ctrl_r <= 2'h0;
      addrReg_r <= 20'h0_0000;
      wdata_r <= 16'h0000;
      plen_r <= 8'h00;
      pidx_r <= 7'h00;
    end else begin
      wrPend_r <= wrPend_nxt;
      wrOff_r <= wrOff_nxt;
      hrdata_r <= hrdata_nxt;
      ctrl_r <= ctrl_nxt;
      addrReg_r <= addrReg_nxt;
      wdata_r <= wdata_nxt;
      plen_r <= plen_nxt;
      pidx_r <= pidx_nxt;
    end
    if (bufWr) begin
      pbuf[pidx_r] <= hwdata[15:0];
    end
  end

  // step table: unlock pair, command, optional second unlock and final code
  always_comb begin
    ldIdx = 7'(step_r - fchs_pkg::FIRST_LOAD_STEP);
    stepAddr = 20'h0_0000;
    stepData = 16'h0000;
    isRead = (op_r == fchs_pkg::OP_READ);
    unique case (op_r)
      fchs_pkg::OP_READ, fchs_pkg::OP_WRITE: lastStep = 8'h00;
      fchs_pkg::OP_PROGRAM: lastStep = 8'(fchs_pkg::LAST_CMD_STEP + plen_r);
      fchs_pkg::OP_CHIPERASE, fchs_pkg::OP_SECTERASE: lastStep = fchs_pkg::LAST_ERASE_STEP;
      default: lastStep = fchs_pkg::LAST_CMD_STEP;
    endcase
    if (op_r == fchs_pkg::OP_READ || op_r == fchs_pkg::OP_WRITE) begin
      stepAddr = addrReg_r;
      stepData = wdata_r;
    end else if (step_r == 8'h00 || step_r == 8'h03 && op_r != fchs_pkg::OP_PROGRAM) begin
      stepAddr = {5'h00, fchs_pkg::UNLOCK_ADDR1};
      stepData = {8'h00, fchs_pkg::UNLOCK_DATA1};
    end else if (step_r == 8'h01 || step_r == 8'h04 && op_r != fchs_pkg::OP_PROGRAM) begin
      stepAddr = {5'h00, fchs_pkg::UNLOCK_ADDR2};
      stepData = {8'h00, fchs_pkg::UNLOCK_DATA2};
    end else if (step_r == fchs_pkg::LAST_CMD_STEP) begin
      stepAddr = {5'h00, fchs_pkg::UNLOCK_ADDR1};
      unique case (op_r)
        fchs_pkg::OP_RESET:   stepData = {8'h00, fchs_pkg::CODE_RESET};
        fchs_pkg::OP_IDREAD:  stepData = {8'h00, fchs_pkg::CODE_IDREAD};
        fchs_pkg::OP_PROGRAM: stepData = {8'h00, fchs_pkg::CODE_PROGRAM};
        fchs_pkg::OP_SUSPEND: stepData = {8'h00, fchs_pkg::CODE_SUSPEND};
        fchs_pkg::OP_STATUS:  stepData = {8'h00, fchs_pkg::CODE_STATUS};
        default:              stepData = {8'h00, fchs_pkg::CODE_ERASE_SETUP};
      endcase
    end else if (op_r == fchs_pkg::OP_PROGRAM) begin
      // page base plus offset, A-1 rides on dq15 in byte mode
      stepAddr = byteMode_r ? {addrReg_r[19:6], ldIdx[6:1]} : {addrReg_r[19:6], ldIdx[5:0]};
      stepData = pbuf[ldIdx];
    end else if (op_r == fchs_pkg::OP_SECTERASE) begin
      stepAddr = {addrReg_r[19:15], 15'h0000};
      stepData = {8'h00, fchs_pkg::CODE_SECT_ERASE};
    end else begin
      stepAddr = {5'h00, fchs_pkg::UNLOCK_ADDR1};
      stepData = {8'h00, fchs_pkg::CODE_CHIP_ERASE};
    end
  end

  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    step_nxt = step_r;
    cnt_nxt = cnt_r;
    byteMode_nxt = byteMode_r;
    rdata_nxt = rdata_r;
    ceN_nxt = ceN_r;
    oeN_nxt = oeN_r;
    weN_nxt = weN_r;
    fa_nxt = fa_r;
    dqo_nxt = dqo_r;
    dqoe_nxt = dqoe_r;
    unique case (st_r)
      S_IDLE: begin
        // commands written while busy are dropped
        // only reads start while the identifier voltage is on
        if (wrPend_r && wrOff_r == fchs_pkg::OFF_CMD
            && (!ctrl_r[fchs_pkg::CTRL_HV_BIT] || hwdata[3:0] == 4'(fchs_pkg::OP_READ))) begin
          op_nxt = fchs_pkg::fchs_op_t'(hwdata[3:0]);
          // width held stable for the whole sequence
          byteMode_nxt = ctrl_r[fchs_pkg::CTRL_BYTE_BIT];
          step_nxt = 8'h00;
          st_nxt = S_SETUP;
        end
      end
      S_SETUP: begin
        fa_nxt = stepAddr;
        ceN_nxt = 1'b0;
        cnt_nxt = 16'h0000;
        if (isRead) begin
          oeN_nxt = 1'b0;
          dqoe_nxt = {~byteMode_r, 15'h7FFF};
          dqo_nxt = {addrReg_r[0], 15'h0000};
          st_nxt = S_RDWAIT;
        end else begin
          // address and data launch with the strobe edge
          weN_nxt = 1'b0;
          dqo_nxt = byteMode_r ? {ldIdx[0] & (op_r == fchs_pkg::OP_PROGRAM), 7'h00, stepData[7:0]}
                               : stepData;
          dqoe_nxt = byteMode_r ? 16'h7F00 : 16'h0000;
          st_nxt = S_STROBE;
        end
      end
      S_STROBE: begin
        cnt_nxt = cnt_r + 16'h0001;
        if (cnt_r == 16'(fchs_pkg::WP_CYC - 1)) begin
          weN_nxt = 1'b1;
          ceN_nxt = 1'b1;
          cnt_nxt = 16'h0000;
          st_nxt = S_RECOV;
        end
      end
      S_RDWAIT: begin
        cnt_nxt = cnt_r + 16'h0001;
        if (cnt_r == 16'(fchs_pkg::ACC_CYC - 1)) begin
          rdata_nxt = byteMode_r ? {8'h00, dqIn[7:0]} : dqIn;
          ceN_nxt = 1'b1;
          oeN_nxt = 1'b1;
          cnt_nxt = 16'h0000;
          st_nxt = S_RECOV;
        end
      end
      // short recovery keeps loads close together
      S_RECOV: begin
        cnt_nxt = cnt_r + 16'h0001;
        dqoe_nxt = 16'hFFFF;
        if (cnt_r == 16'(fchs_pkg::WPH_CYC - 1)) begin
          cnt_nxt = 16'h0000;
          step_nxt = step_r + 8'h01;
          if (step_r != lastStep) begin
            st_nxt = S_SETUP;
          end else if (op_r == fchs_pkg::OP_PROGRAM) begin
            st_nxt = S_LOADEND;
          end else begin
            st_nxt = S_IDLE;
          end
        end
      end
      S_LOADEND: begin
        // no strobe until the device closes the load period
        cnt_nxt = cnt_r + 16'h0001;
        if (cnt_r == 16'(LOAD_END_CYC)) begin
          st_nxt = S_IDLE;
        end
      end
      default: st_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r <= S_IDLE;
      op_r <= fchs_pkg::OP_READ;
      step_r <= 8'h00;
      cnt_r <= 16'h0000;
      byteMode_r <= 1'b0;
      rdata_r <= 16'h0000;
      ceN_r <= 1'b1;
      oeN_r <= 1'b1;
      weN_r <= 1'b1;
      fa_r <= 20'h0_0000;
      dqo_r <= 16'h0000;
      dqoe_r <= 16'hFFFF;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      step_r <= step_nxt;
      cnt_r <= cnt_nxt;
      byteMode_r <= byteMode_nxt;
      rdata_r <= rdata_nxt;
      ceN_r <= ceN_nxt;
      oeN_r <= oeN_nxt;
      weN_r <= weN_nxt;
      fa_r <= fa_nxt;
      dqo_r <= dqo_nxt;
      dqoe_r <= dqoe_nxt;
    end
  end

  assign flashCeN = ceN_r;
  assign flashOeN = oeN_r;
  assign flashWeN = weN_r;
  assign flashAddr = fa_r;
  assign dqOut = dqo_r;
  assign dqOeN = dqoe_r;
  assign flashByteN = ~byteMode_r;
  // high voltage on A9 only from the control bit
  assign identifierHighVoltage = ctrl_r[fchs_pkg::CTRL_HV_BIT];

  // load spacing watch, only read by an assertion
  logic [15:0] gap_r;
  always_ff @(posedge core_clk) begin
    // only the strobe-high span between two loads counts
    if (srst || !(st_r == S_RECOV || st_r == S_SETUP) || op_r != fchs_pkg::OP_PROGRAM
        || step_r < fchs_pkg::FIRST_LOAD_STEP) begin
      gap_r <= 16'h0000;
    end else begin
      gap_r <= gap_r + 16'h0001;
    end
  end

  a_hv_no_write: assert property (@(posedge core_clk) disable iff (srst)
    identifierHighVoltage |-> flashWeN) else $error("write strobe under identifier voltage");
  a_unlock_first: assert property (@(posedge core_clk) disable iff (srst)
    $fell(flashWeN) && step_r == 8'h00 && op_r > fchs_pkg::OP_WRITE
    |-> flashAddr[14:0] == 15'h5555 && dqOut[7:0] == 8'hAA) else $error("bad first unlock");
  a_unlock_second: assert property (@(posedge core_clk) disable iff (srst)
    $fell(flashWeN) && step_r == 8'h01 && op_r > fchs_pkg::OP_WRITE
    |-> flashAddr[14:0] == 15'h2AAA && dqOut[7:0] == 8'h55) else $error("bad second unlock");
  a_prog_code: assert property (@(posedge core_clk) disable iff (srst)
    $fell(flashWeN) && step_r == 8'h02 && op_r == fchs_pkg::OP_PROGRAM |-> dqOut[7:0] == 8'hA0)
    else $error("bad program code");
  a_chip_final: assert property (@(posedge core_clk) disable iff (srst)
    $fell(flashWeN) && step_r == 8'h05 && op_r == fchs_pkg::OP_CHIPERASE |-> dqOut[7:0] == 8'h10)
    else $error("bad chip erase code");
  a_sect_final: assert property (@(posedge core_clk) disable iff (srst)
    $fell(flashWeN) && step_r == 8'h05 && op_r == fchs_pkg::OP_SECTERASE
    |-> dqOut[7:0] == 8'h30 && flashAddr[19:15] == addrReg_r[19:15]) else $error("bad sector erase");
  a_id_code: assert property (@(posedge core_clk) disable iff (srst)
    $fell(flashWeN) && step_r == 8'h02 && op_r == fchs_pkg::OP_IDREAD |-> dqOut[7:0] == 8'h90)
    else $error("bad identifier code");
  a_load_gap: assert property (@(posedge core_clk) disable iff (srst)
    gap_r < 16'(fchs_pkg::LOAD_GAP_CYC)) else $error("load spacing over limit");
  a_strobe_width: assert property (@(posedge core_clk) disable iff (srst)
    $fell(flashWeN) |-> !flashWeN[*5] ##1 flashWeN) else $error("strobe width wrong");
  a_load_close: assert property (@(posedge core_clk) disable iff (srst)
    st_r == S_LOADEND |-> flashWeN && flashCeN) else $error("strobe during load close");

  c_program: cover property (@(posedge core_clk) st_r == S_LOADEND ##1 st_r == S_IDLE);
  c_sect_erase: cover property (@(posedge core_clk) op_r == fchs_pkg::OP_SECTERASE && step_r == 8'h05);
  c_read: cover property (@(posedge core_clk) st_r == S_RDWAIT ##1 st_r == S_RECOV);
endmodule

// file: include/fchs_pkg.sv
// What this block does
// - high voltage on A9 selects identifier mode
// - identifier command mode; leave with read/reset
// - two unlocks then program code
// - next load within 30 us
// - chip erase six writes ending 10h
// - sector erase six writes ending 30h
// - unlock writes AAh@5555h then 55h@2AAAh
package fchs_pkg;
  localparam int CLK_NS = 10;
  localparam int T_WP_NS = 50;
  localparam int T_WPH_NS = 30;
  localparam int T_ACC_NS = 100;
  localparam int T_LOAD_GAP_US = 30;
  localparam int T_LOAD_END_US = 100;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WPH_CYC = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOAD_GAP_CYC = (T_LOAD_GAP_US * 1000) / CLK_NS;
  localparam int LOAD_END_CYC = (T_LOAD_END_US * 1000 + CLK_NS - 1) / CLK_NS;
  // bus register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_ADDR = 8'h08;
  localparam logic [7:0] OFF_WDATA = 8'h0C;
  localparam logic [7:0] OFF_RDATA = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_PBUF = 8'h18;
  localparam logic [7:0] OFF_PLEN = 8'h1C;
  localparam int CTRL_BYTE_BIT = 0;
  localparam int CTRL_HV_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_READY_BIT = 1;
  localparam int STAT_SUSP_BIT = 2;
  localparam int DQ_READY_BIT = 7;
  localparam int DQ_SUSP_BIT = 6;
  // operations started by a write to CMD
  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_WRITE = 4'h1, OP_RESET = 4'h2, OP_IDREAD = 4'h3,
    OP_PROGRAM = 4'h4, OP_CHIPERASE = 4'h5, OP_SECTERASE = 4'h6,
    OP_SUSPEND = 4'h7, OP_STATUS = 4'h8
  } fchs_op_t;
  localparam logic [14:0] UNLOCK_ADDR1 = 15'h5555;
  localparam logic [14:0] UNLOCK_ADDR2 = 15'h2AAA;
  localparam logic [7:0] UNLOCK_DATA1 = 8'hAA;
  localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
  localparam logic [7:0] CODE_RESET = 8'hF0;
  localparam logic [7:0] CODE_IDREAD = 8'h90;
  localparam logic [7:0] CODE_PROGRAM = 8'hA0;
  localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CODE_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CODE_SECT_ERASE = 8'h30;
  localparam logic [7:0] CODE_SUSPEND = 8'hB0;
  localparam logic [7:0] CODE_STATUS = 8'h70;
  localparam logic [7:0] LAST_CMD_STEP = 8'h02;
  localparam logic [7:0] LAST_ERASE_STEP = 8'h05;
  localparam logic [7:0] FIRST_LOAD_STEP = 8'h03;
  localparam int PAGE_BYTES = 128;
  localparam int PAGE_WORDS = 64;
endpackage

// file: verif/fchs_flash_model.sv
`timescale 1ns/1ns
module fchs_flash_model #(
  parameter logic [7:0] MFR_CODE = 8'h5A,
  parameter logic [7:0] DEV_CODE = 8'h3C,
  parameter int         T_LOAD   = 150,
  parameter int         T_BUSY   = 3000
) (
  input  wire logic        ceN,
  input  wire logic        oeN,
  input  wire logic        weN,
  input  wire logic        byteN,
  input  wire logic        hv,
  input  wire logic [19:0] addr,
  input  wire logic [15:0] dqOut,
  input  wire logic [15:0] dqOeN,
  output logic [15:0]      dqIn
);
  // id codes are arbitrary; only the lowest sector is protected here
  logic [7:0]  mem [int];
  logic [7:0]  pg [int];
  int          seq = 0, mode = 0, falls = 0, opId = 0;
  logic        ready = 1'b1, susp = 1'b0, erasing = 1'b0, loading = 1'b0, byteMode = 1'b0;
  logic [19:0] la;
  logic [15:0] rdv = 16'h0000;
  logic [15:0] drv;
  wire         wr = !ceN && !weN && oeN;
  wire         rd = !ceN && !oeN && weN;
  function automatic logic [7:0] getb(int a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  // drive on reads only; released lines show the inverse so stale data never passes
  assign drv  = rd ? (byteN ? 16'hFFFF : 16'h00FF) : 16'h0000;
  assign dqIn = (~dqOeN & dqOut) | (dqOeN & drv & rdv) | (dqOeN & ~drv & ~rdv);
  always @(*) begin
    int b;
    b = byteN ? {addr, 1'b0} : {addr, dqOut[15]};
    if (rd) begin
      if (mode == 2)
        rdv = {8'h00, ready, susp, 6'h00};
      else if (mode == 1 || hv)
        rdv = {8'h00, !addr[1] ? (addr[0] ? DEV_CODE : MFR_CODE)
                               : ((addr[19:15] == 5'h00 && !addr[0]) ? MFR_CODE : 8'h00)};
      else
        rdv = byteN ? {getb(b + 1), getb(b)} : {8'h00, getb(b)};
    end
  end
  // address on later fall, width at third write
  always @(posedge wr) begin
    // strobes and address share one launch edge; let the address settle first
    #1;
    la = addr;
    falls++;
    if (seq == 2)
      byteMode = !byteN;
  end
  task automatic load_timer();
    fork begin
      int n = falls;
      #(T_LOAD);
      if (loading && n == falls) begin
        loading = 1'b0;
        ready = 1'b0;
        mode = 2;
        #(T_BUSY);
        foreach (pg[k]) mem[k] = getb(k) & pg[k];
        ready = 1'b1;
      end
    end join_none
  endtask
  // erase of chip or one sector
  task automatic erase(input logic chip, input logic [4:0] s);
    seq = 0;
    mode = 2;
    ready = 1'b0;
    erasing = 1'b1;
    opId++;
    fork begin
      int id = opId;
      int ks[$];
      #(T_BUSY);
      if (id == opId) begin
        foreach (mem[k]) if (chip || k[20:16] == s) ks.push_back(k);
        foreach (ks[i]) mem.delete(ks[i]);
        ready = 1'b1;
        erasing = 1'b0;
      end
    end join_none
  endtask
  task automatic command(input logic [7:0] d);
    seq = 0;
    if (susp) begin
      if (d == 8'hF0) mode = 0;
      if (d == 8'h70) mode = 2;
    end else if (!ready) begin
      if (d == 8'h70) mode = 2;
      if (d == 8'hB0 && erasing) begin
        susp = 1'b1;
        mode = 2;
        opId++;
        fork #(100) ready = 1'b1; join_none
      end
    end else case (d)
      8'hF0: mode = 0;
      8'h90: mode = 1;
      8'h70: mode = 2;
      8'h80: seq = 3;
      8'hA0: begin
        loading = 1'b1;
        pg.delete();
      end
      default: ;
    endcase
  endtask
  always @(negedge wr) begin
    logic [7:0] d;
    int         b;
    d = dqIn[7:0];
    b = byteMode ? {la, dqIn[15]} : {la, 1'b0};
    if (loading) begin
      pg[b] = d;
      if (!byteMode)
        pg[b + 1] = dqIn[15:8];
      load_timer();
    end else if ((seq == 0 || seq == 3) && la[14:0] == 15'h5555 && d == 8'hAA)
      seq++;
    else if ((seq == 1 || seq == 4) && la[14:0] == 15'h2AAA && d == 8'h55)
      seq++;
    else if (seq == 2 && la[14:0] == 15'h5555)
      command(d);
    else if (seq == 5 && ready && !susp && (d == 8'h10 || d == 8'h30))
      erase(d == 8'h10, la[19:15]);
    else
      seq = 0;
  end
endmodule

// file: verif/tb.sv
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  localparam logic [7:0] MFR = 8'h5A;
  localparam logic [7:0] DEV = 8'h3C;
  logic        core_clk, srst, hsel, hwrite, hreadyout, hresp, ceN, oeN, weN, byteN, hv;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [19:0] fa;
  logic [15:0] dqIn, dqOut, dqOeN, v;
  int          failures = 0, tests_run = 0, seed = 55876;
  logic [7:0]  refB [int];
  fchs_host #(.LOAD_END_CYC(20)) DUT (.core_clk(core_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .flashCeN(ceN), .flashOeN(oeN),
    .flashWeN(weN), .flashByteN(byteN), .identifierHighVoltage(hv), .flashAddr(fa), .dqIn(dqIn),
    .dqOut(dqOut), .dqOeN(dqOeN));
  fchs_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) flash (.ceN(ceN), .oeN(oeN), .weN(weN),
    .byteN(byteN), .hv(hv), .addr(fa), .dqOut(dqOut), .dqOeN(dqOeN), .dqIn(dqIn));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic finish_test();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wait_rdy();
    do begin
      @(posedge core_clk);
    end while (hreadyout !== 1'b1);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    haddr <= {24'h00_0000, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask
  task automatic op(input logic [3:0] c, input logic [19:0] a, input logic [15:0] d);
    bus(1'b1, fchs_pkg::OFF_ADDR, {12'h000, a});
    bus(1'b1, fchs_pkg::OFF_WDATA, {16'h0000, d});
    bus(1'b1, fchs_pkg::OFF_CMD, {28'h000_0000, c});
    do begin
      bus(1'b0, fchs_pkg::OFF_STATUS, 32'h0000_0000);
    end while (q[fchs_pkg::STAT_BUSY_BIT] !== 1'b0);
  endtask
  task automatic fread(input logic [19:0] a);
    op(fchs_pkg::OP_READ, a, 16'h0000);
    bus(1'b0, fchs_pkg::OFF_RDATA, 32'h0000_0000);
    v = q[15:0];
  endtask
  task automatic rdchk(input logic [19:0] a, input logic [15:0] e);
    fread(a);
    `CHK(v, e)
  endtask
  function automatic logic [7:0] rb(int a);
    return refB.exists(a) ? refB[a] : 8'hFF;
  endfunction
  task automatic chkw(input logic [19:0] a);
    rdchk(a, {rb({a, 1'b1}), rb({a, 1'b0})});
  endtask
  task automatic poll();
    for (int n = 0; n < 100; n++) begin
      fread(20'h0_0000);
      if (v[7] === 1'b1) break;
    end
  endtask
  task automatic prog(input logic [19:0] pa, input int n, input logic bm);
    logic [31:0] d;
    bus(1'b1, fchs_pkg::OFF_CTRL, {31'h0000_0000, bm});
    bus(1'b1, fchs_pkg::OFF_PLEN, 32'(n));
    for (int i = 0; i < n; i++) begin
      d = {16'h0000, 16'($random(seed))};
      bus(1'b1, fchs_pkg::OFF_PBUF, d);
      if (bm)
        refB[{pa[19:6], i[6:0]}] = d[7:0];
      else
        {refB[{pa[19:6], i[5:0], 1'b1}], refB[{pa[19:6], i[5:0], 1'b0}]} = d[15:0];
    end
    op(fchs_pkg::OP_PROGRAM, pa, 16'h0000);
    bus(1'b1, fchs_pkg::OFF_CTRL, 32'h0000_0000);
    poll();
    `CHK(v, 16'h0080)
    op(fchs_pkg::OP_RESET, 20'h0_0000, 16'h0000);
  endtask
  initial begin
    #(500_000);
    failures++;
    finish_test();
  end
  initial begin
    srst = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    hsize = 3'b000;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    bus(1'b0, fchs_pkg::OFF_STATUS, 32'h0000_0000);
    `CHK(q, 32'h0000_0000)
    bus(1'b0, 8'h40, 32'h0000_0000);
    `CHK(q, 32'h0000_0000)
    rdchk(20'($random(seed)), 16'hFFFF);
    prog(20'h0_8040, 5, 1'b0);
    for (int i = 0; i < 6; i++) chkw(20'h0_8040 + 20'(i));
    prog(20'h1_8000, 9, 1'b1);
    for (int i = 0; i < 6; i++) chkw(20'h1_8000 + 20'(i));
    op(fchs_pkg::OP_WRITE, 20'h0_8040, 16'h0000);
    chkw(20'h0_8040);
    op(fchs_pkg::OP_IDREAD, 20'h0_0000, 16'h0000);
    rdchk(20'h0_0000, {8'h00, MFR});
    rdchk(20'h0_0001, {8'h00, DEV});
    rdchk(20'h0_0002, {8'h00, MFR});
    rdchk(20'hF_8002, 16'h0000);
    op(fchs_pkg::OP_RESET, 20'h0_0000, 16'h0000);
    chkw(20'h0_8041);
    bus(1'b1, fchs_pkg::OFF_CTRL, 32'h0000_0002);
    rdchk(20'h3_0001, {8'h00, DEV});
    bus(1'b1, fchs_pkg::OFF_CTRL, 32'h0000_0000);
    op(fchs_pkg::OP_SECTERASE, 20'h0_8123, 16'h0000);
    op(fchs_pkg::OP_RESET, 20'h0_0000, 16'h0000);
    rdchk(20'h0_0000, 16'h0000);
    poll();
    `CHK(v, 16'h0080)
    for (int k = 32'h0001_0000; k < 32'h0002_0000; k++) refB.delete(k);
    op(fchs_pkg::OP_RESET, 20'h0_0000, 16'h0000);
    chkw(20'h0_8040);
    chkw(20'h1_8000);
    op(fchs_pkg::OP_CHIPERASE, 20'h0_0000, 16'h0000);
    poll();
    `CHK(v, 16'h0080)
    refB.delete();
    op(fchs_pkg::OP_RESET, 20'h0_0000, 16'h0000);
    chkw(20'h1_8000);
    prog(20'h1_8000, 2, 1'b0);
    op(fchs_pkg::OP_CHIPERASE, 20'h0_0000, 16'h0000);
    op(fchs_pkg::OP_SUSPEND, 20'h0_0000, 16'h0000);
    poll();
    `CHK(v, 16'h00C0)
    op(fchs_pkg::OP_IDREAD, 20'h0_0000, 16'h0000);
    rdchk(20'h0_0000, 16'h00C0);
    op(fchs_pkg::OP_STATUS, 20'h0_0000, 16'h0000);
    rdchk(20'h0_0001, 16'h00C0);
    op(fchs_pkg::OP_RESET, 20'h0_0000, 16'h0000);
    chkw(20'h1_8001);
    finish_test();
  end
endmodule
